// ==== rtl/down_counter.sv ====
// Down counter that reloads itself on reaching zero.
// Assumes the owner supplies the reload value and the run level.
`timescale 1ns/1ps

module down_counter
#(
    parameter int              WIDTH     = 32,
    parameter logic [63:0]     RESET_VAL = 64'h0000000000000000
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // Control
    input  wire logic              run,
    input  wire logic              load,
    input  wire logic [WIDTH-1:0]  load_val,
    // State
    output logic      [WIDTH-1:0]  count,
    output logic                   zero_hit
);

    logic [WIDTH-1:0] count_r;   // Current count

    ////////////////////////////////////////////////////////////////////
    // Zero is seen only while running
    assign zero_hit = run && (count_r == '0);
    assign count    = count_r;

    ////////////////////////////////////////////////////////////////////
    // Forced load, reload at zero, otherwise step down
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_r <= RESET_VAL[WIDTH-1:0];
        end
        else if (load || zero_hit)
        begin
            count_r <= load_val;
        end
        else if (run)
        begin
            count_r <= count_r - WIDTH'(1);
        end
    end

endmodule

// ==== rtl/interval_watchdog_timer.sv ====
// Interval timer with optional watchdog, pulse and snapshot features.
// Assumes a single clock and a simple word-indexed register port.
//
// Operation
// - All software registers are 16 bits wide
// - Counter counts down, reloads period at zero
// - Snapshot write latches whole count; master reads
// - Zero with interrupts enabled raises interrupt
// - Optional pulse output high one cycle at zero
// - Watchdog reset request pulses one cycle at zero
// - Fixed period: period writes only reload the count
// - Period after reset equals build timeout
// - Timeout time rounds up to whole cycles
// - Width 32 or 64; two or four words
// - No snapshot option: snapshot reads zero
// - Start/stop bits control run; else free-running
// - Watchdog keeps start bit without start/stop option
// - Watchdog stopped after reset until start written
// - Running watchdog can never be stopped
// - Watchdog period write reloads fixed period
// - Control sets run, interrupt enable, mode
// - Simple periodic: fixed, unstoppable, enable writable
// - Timeout flag set at zero, cleared by write
// - Run bit shows running, unaffected by writes
// - Continuous bit: keep counting or halt at zero
// - Start while stopped resumes from held count
`timescale 1ns/1ps

module interval_watchdog_timer
#(
    parameter int          COUNTER_WIDTH     = 32,
    parameter logic [63:0] TIMEOUT_NS        = 64'h00000000000F4240,
    parameter bit          WRITABLE_PERIOD   = 1'b1,
    parameter bit          READABLE_SNAPSHOT = 1'b1,
    parameter bit          START_STOP_CTRL   = 1'b1,
    parameter bit          PULSE_OUTPUT      = 1'b1,
    parameter bit          WATCHDOG          = 1'b0
)
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Register port, word indexed
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [timer_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [timer_pkg::REG_W-1:0]   reg_wdata,
    output logic      [timer_pkg::REG_W-1:0]   reg_rdata,
    output logic                               reg_rvalid,
    // Events
    output logic                               irq,
    output logic                               timeout_pulse,
    output logic                               reset_request
);

    ////////////////////////////////////////////////////////////////////
    // Derived build constants
    // Words per wide value: two for 32 bits, four for 64 bits
    localparam int NWORDS = COUNTER_WIDTH / timer_pkg::REG_W;

    // Timeout converted to cycles, rounded up, never below one
    localparam logic [63:0] TIMEOUT_PS = TIMEOUT_NS * timer_pkg::PS_PER_NS;
    localparam logic [63:0] RAW_CYCLES =
        (TIMEOUT_PS + timer_pkg::CLK_PERIOD_PS - timer_pkg::ONE_CYCLE)
        / timer_pkg::CLK_PERIOD_PS;
    localparam logic [63:0] PERIOD_CYCLES =
        (RAW_CYCLES == 64'h0) ? timer_pkg::ONE_CYCLE : RAW_CYCLES;

    // Registers hold the period minus one
    localparam logic [63:0] FIXED_PERIOD =
        PERIOD_CYCLES - timer_pkg::ONE_CYCLE;
    // Snapshot words follow the period words
    localparam logic [3:0] SNAP_BASE =
        timer_pkg::PERIOD_BASE + 4'(NWORDS);
    localparam logic [3:0] MAP_END = SNAP_BASE + 4'(NWORDS);

    // Whether the master may stop the counter; a watchdog never stops
    localparam bit STOPPABLE = START_STOP_CTRL && !WATCHDOG;
    // Whether a start bit exists
    localparam bit HAS_START = START_STOP_CTRL || WATCHDOG;
    // Run level straight after reset
    localparam bit RUN_AT_RESET = !HAS_START;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic                     run_r;          // Counter running
    logic                     timeout_flag_r; // Sticky zero flag
    logic                     irq_enable_r;   // Interrupt enable bit
    logic                     continuous_r;   // Continuous mode bit
    logic                     load_pend_r;    // Period write reload
    logic                     pulse_r;        // Zero strobe register
    logic                     rst_req_r;      // Reset request register
    logic [15:0]              rdata_r;        // Read data register
    logic                     rvalid_r;       // Read data valid

    logic [COUNTER_WIDTH-1:0] count;          // Live count
    logic                     zero_hit;       // Counter at zero now
    logic [COUNTER_WIDTH-1:0] period_bank;    // Writable period value
    logic [COUNTER_WIDTH-1:0] active_period;  // Period in force
    logic [COUNTER_WIDTH-1:0] snap_bank;      // Captured count

    logic                     hit_status;     // Status selected
    logic                     hit_control;    // Control selected
    logic                     hit_period;     // A period word selected
    logic                     hit_snap;       // A snapshot word selected
    logic [3:0]               period_off;     // Offset into periods
    logic [3:0]               snap_off;       // Offset into snapshots
    logic [1:0]               period_widx;    // Period word index
    logic [1:0]               snap_widx;      // Snapshot word index

    logic                     wr_status;      // Status write
    logic                     wr_control;     // Control write
    logic                     wr_period;      // Period word write
    logic                     wr_snap;        // Snapshot word write
    logic                     start_req;      // Start bit written
    logic                     stop_req;       // Stop bit written
    logic                     period_store;   // Period data kept

    ////////////////////////////////////////////////////////////////////
    // Address decode; every register is one 16-bit word
    assign hit_status  = (reg_addr == timer_pkg::STATUS_IDX);
    assign hit_control = (reg_addr == timer_pkg::CONTROL_IDX);
    assign hit_period  = (reg_addr >= timer_pkg::PERIOD_BASE)
                      && (reg_addr <  SNAP_BASE);
    assign hit_snap    = (reg_addr >= SNAP_BASE)
                      && (reg_addr <  MAP_END);

    // Word index within each group
    assign period_off  = reg_addr - timer_pkg::PERIOD_BASE;
    assign snap_off    = reg_addr - SNAP_BASE;
    assign period_widx = period_off[1:0];
    assign snap_widx   = snap_off[1:0];

    // Write strobes per register
    assign wr_status  = reg_wr && hit_status;
    assign wr_control = reg_wr && hit_control;
    assign wr_period  = reg_wr && hit_period;
    assign wr_snap    = reg_wr && hit_snap;

    // Start and stop event bits of a control write
    assign start_req = wr_control && HAS_START
                    && reg_wdata[timer_pkg::START_BIT];
    assign stop_req  = wr_control && STOPPABLE
                    && reg_wdata[timer_pkg::STOP_BIT];

    // Period data is kept only when writable and not a watchdog
    assign period_store = wr_period && WRITABLE_PERIOD
                       && !WATCHDOG;

    ////////////////////////////////////////////////////////////////////
    // Period registers
    // Bank stores writes only when the period is writable and not a watchdog
    word_bank
    #(
        .NWORDS    (NWORDS),
        .RESET_VAL (FIXED_PERIOD)
    )
    u_period_bank
    (
        .clk      (clk),
        .srst     (srst),
        .wr_en    (period_store),
        .wr_idx   (period_widx),
        .wr_data  (reg_wdata),
        .load_en  (1'b0),
        .load_val ({COUNTER_WIDTH{1'b0}}),
        .value    (period_bank)
    );

    // Fixed period when not writable or in watchdog use
    assign active_period = (WRITABLE_PERIOD && !WATCHDOG)
                         ? period_bank
                         : FIXED_PERIOD[COUNTER_WIDTH-1:0];

    ////////////////////////////////////////////////////////////////////
    // Counter core
    // Loads on period write, reloads at zero, else counts down
    down_counter
    #(
        .WIDTH     (COUNTER_WIDTH),
        .RESET_VAL (FIXED_PERIOD)
    )
    u_counter
    (
        .clk      (clk),
        .srst     (srst),
        .run      (run_r),
        .load     (load_pend_r),
        .load_val (active_period),
        .count    (count),
        .zero_hit (zero_hit)
    );

    ////////////////////////////////////////////////////////////////////
    // Reload request one cycle after a period write
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            load_pend_r <= 1'b0;
        end
        else
        begin
            // Any period write reloads; data ignored in watchdog use
            load_pend_r <= wr_period;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Snapshot registers
    // Any snapshot write captures every word of the count at once
    word_bank
    #(
        .NWORDS    (NWORDS),
        .RESET_VAL (64'h0000000000000000)
    )
    u_snap_bank
    (
        .clk      (clk),
        .srst     (srst),
        .wr_en    (1'b0),
        .wr_idx   (snap_widx),
        .wr_data  (reg_wdata),
        .load_en  (wr_snap && READABLE_SNAPSHOT),
        .load_val (count),
        .value    (snap_bank)
    );

    ////////////////////////////////////////////////////////////////////
    // Run state
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            // Watchdog and start/stop builds come up stopped
            run_r <= RUN_AT_RESET;
        end
        else if (!HAS_START)
        begin
            // No start or stop bits: always counting
            run_r <= 1'b1;
        end
        else if (stop_req)
        begin
            // Stop wins over a start in the same write
            run_r <= 1'b0;
        end
        else if (zero_hit && STOPPABLE && !continuous_r)
        begin
            // One-shot mode halts after the reload
            run_r <= 1'b0;
        end
        else if (start_req && !run_r)
        begin
            // Resume from the held count
            run_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register bits
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_enable_r <= 1'b0;
            continuous_r <= 1'b0;
        end
        else if (wr_control)
        begin
            // Enable stays writable in every build
            irq_enable_r <= reg_wdata[timer_pkg::IRQ_EN_BIT];
            continuous_r <= reg_wdata[timer_pkg::CONTINUOUS_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Timeout flag
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            timeout_flag_r <= 1'b0;
        end
        else if (zero_hit)
        begin
            // A zero in the clearing cycle is kept
            timeout_flag_r <= 1'b1;
        end
        else if (wr_status)
        begin
            // Any status write clears the flag
            timeout_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Zero strobes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pulse_r   <= 1'b0;
            rst_req_r <= 1'b0;
        end
        else
        begin
            // One cycle per zero; stay low when not built
            pulse_r   <= zero_hit && PULSE_OUTPUT;
            rst_req_r <= zero_hit && WATCHDOG;
        end
    end

    assign timeout_pulse = pulse_r;
    assign reset_request = rst_req_r;

    // Interrupt level from enable and flag
    assign irq = irq_enable_r && timeout_flag_r;

    ////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rdata_r  <= timer_pkg::READ_ZERO;
            rvalid_r <= 1'b0;
        end
        else
        begin
            // Without a read the last answer holds
            rvalid_r <= reg_rd;
            if (reg_rd && hit_status)
            begin
                // Run level and timeout flag; writes never set run
                rdata_r <= timer_pkg::READ_ZERO;
                rdata_r[timer_pkg::RUN_BIT]     <= run_r;
                rdata_r[timer_pkg::TIMEOUT_BIT] <= timeout_flag_r;
            end
            else if (reg_rd && hit_control)
            begin
                // Event bits read as zero
                rdata_r <= timer_pkg::READ_ZERO;
                rdata_r[timer_pkg::IRQ_EN_BIT]     <= irq_enable_r;
                rdata_r[timer_pkg::CONTINUOUS_BIT] <= continuous_r;
            end
            else if (reg_rd && hit_period && WRITABLE_PERIOD)
            begin
                rdata_r <= period_bank[period_widx*16 +: 16];
            end
            else if (reg_rd && hit_snap && READABLE_SNAPSHOT)
            begin
                rdata_r <= snap_bank[snap_widx*16 +: 16];
            end
            else if (reg_rd)
            begin
                // Absent or unmapped words read as zero
                rdata_r <= timer_pkg::READ_ZERO;
            end
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;

endmodule

// ==== rtl/timer_pkg.sv ====
// Shared constants of the interval and watchdog timer.
// Assumes one 40 MHz clock; register port addresses are word indices.
package timer_pkg;

    // Register geometry
    localparam int          REG_W        = 16;
    localparam int          ADDR_W       = 4;
    localparam int          WIDX_W       = 2;

    // Register indices
    localparam logic [3:0]  STATUS_IDX   = 4'h0;
    localparam logic [3:0]  CONTROL_IDX  = 4'h1;
    localparam logic [3:0]  PERIOD_BASE  = 4'h2;

    // Status bit positions
    localparam int          TIMEOUT_BIT  = 0;
    localparam int          RUN_BIT      = 1;

    // Control bit positions
    localparam int          IRQ_EN_BIT   = 0;
    localparam int          CONTINUOUS_BIT = 1;
    localparam int          START_BIT    = 2;
    localparam int          STOP_BIT     = 3;

    // Clock period in picoseconds (40 MHz)
    localparam logic [63:0] CLK_PERIOD_PS = 64'h00000000000061A8;
    localparam logic [63:0] PS_PER_NS     = 64'h00000000000003E8;
    localparam logic [63:0] ONE_CYCLE     = 64'h0000000000000001;

    // Read value of reserved, absent and unmapped locations
    localparam logic [15:0] READ_ZERO    = 16'h0000;

endpackage

// ==== rtl/word_bank.sv ====
// Bank of 16-bit words that together hold one wide value.
// Assumes the owner decodes which word a bus write targets.
`timescale 1ns/1ps

module word_bank
#(
    parameter int              NWORDS    = 2,
    parameter logic [63:0]     RESET_VAL = 64'h0000000000000000
)
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // Single word write
    input  wire logic                          wr_en,
    input  wire logic [timer_pkg::WIDX_W-1:0]  wr_idx,
    input  wire logic [timer_pkg::REG_W-1:0]   wr_data,
    // Whole value load
    input  wire logic                          load_en,
    input  wire logic [NWORDS*16-1:0]          load_val,
    // Stored value
    output logic      [NWORDS*16-1:0]          value
);

    localparam int WIDX_W = timer_pkg::WIDX_W;   // Word index width

    genvar g;

    ////////////////////////////////////////////////////////////////////
    // One register per word; a whole load beats a word write
    generate
        for (g = 0; g < NWORDS; g++)
        begin : g_word
            logic [15:0] word_r;   // Stored word

            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    word_r <= RESET_VAL[g*16 +: 16];
                end
                else if (load_en)
                begin
                    word_r <= load_val[g*16 +: 16];
                end
                else if (wr_en && (wr_idx == WIDX_W'(g)))
                begin
                    word_r <= wr_data;
                end
            end

            assign value[g*16 +: 16] = word_r;
        end
    endgenerate

endmodule

// ==== testbench/interval_watchdog_timer_bench.sv ====
// Self-checking bench for the default timer build: every option on except the watchdog.
// Assumes a 100 ns timeout, so the reset period is four cycles and its register reads three.
`timescale 1ns/1ps

module interval_watchdog_timer_bench;
    // Clock, reset and ports
    logic        clk;
    logic        srst;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        irq;
    logic        timeout_pulse;
    logic        reset_request;
    // Bookkeeping
    int          err_total;
    int          tests_run;
    int          cycles;
    int          exp_q[$];
    logic [15:0] d;
    logic        ok;
    int          n;
    int          p;

    ////////////////////////////////////////////////////////////////////
    master_model bus_u
    (
        .clk        (clk),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid)
    );

    interval_watchdog_timer
    #(
        .TIMEOUT_NS (64'h0000000000000064)
    )
    dut_u
    (
        .clk           (clk),
        .srst          (srst),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_rdata     (reg_rdata),
        .reg_rvalid    (reg_rvalid),
        .irq           (irq),
        .timeout_pulse (timeout_pulse),
        .reset_request (reset_request)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock at 25 ns period
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            final_report();
        end
    end

    // Compare one value against its expectation
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", what, e, g);
            err_total++;
        end
    endtask

    // Read a word and compare both answer and data
    task automatic rchk(string what, logic [3:0] a, logic [15:0] e);
        bus_u.rd(a, d, ok);
        chk("read valid", 16'h0001, {15'h0000, ok});
        chk(what, e, d);
    endtask

    // Cycles between two successive zero pulses
    task automatic gap(output int c);
        #1;
        while (timeout_pulse !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        c = 0;
        do
        begin
            @(posedge clk);
            #1;
            c++;
        end
        while (timeout_pulse !== 1'b1 && c < 100);
    endtask

    // Verdict
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        void'($urandom(32'h51E8));
        // Reset state: stopped, period rounded up from 100 ns
        rchk("status", 4'h0, 16'h0000);
        rchk("period lo", 4'h2, 16'((100 + 24) / 25 - 1));
        rchk("period hi", 4'h3, 16'h0000);
        rchk("unmapped", 4'hF, 16'h0000);
        $display("test reset done");
        // Continuous run with interrupt enabled
        bus_u.wr(4'h1, 16'h0007);
        gap(n);
        chk("gap", 16'h0004, 16'(n));
        chk("reset request", 16'h0000, {15'h0000, reset_request});
        chk("irq", 16'h0001, {15'h0000, irq});
        rchk("status", 4'h0, 16'h0003);
        // Stop, clear flag, irq must follow
        bus_u.wr(4'h1, 16'h0009);
        bus_u.wr(4'h0, 16'h0000);
        rchk("status", 4'h0, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        $display("test run stop done");
        // Random periods
        repeat (3)
        begin
            p = 2 + int'($urandom % 6);
            exp_q.push_back(p);
            bus_u.wr(4'h2, 16'(p));
            bus_u.wr(4'h3, 16'h0000);
            rchk("period", 4'h2, 16'(exp_q[0]));
            bus_u.wr(4'h1, 16'h0006);
            gap(n);
            chk("gap", 16'(exp_q.pop_front() + 1), 16'(n));
            bus_u.wr(4'h1, 16'h0008);
            bus_u.wr(4'h0, 16'h0000);
        end
        $display("test period done");
        // One-shot: reload then halt, snapshot shows period
        bus_u.wr(4'h1, 16'h0004);
        gap(n);
        chk("one shot gap", 16'h0064, 16'(n));
        repeat (3) @(posedge clk);
        rchk("status", 4'h0, 16'h0001);
        chk("irq", 16'h0000, {15'h0000, irq});
        bus_u.wr(4'h4, 16'h0000);
        rchk("snap lo", 4'h4, 16'(p));
        rchk("snap hi", 4'h5, 16'h0000);
        $display("test one shot done");
        final_report();
    end
endmodule

// ==== testbench/master_model.sv ====
// Bus master model that issues single word reads and writes.
// Assumes the timer answers a read exactly one cycle after it.
`timescale 1ns/1ps

module master_model
(
    // Clock
    input wire logic        clk,
    // Requests toward the timer
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [3:0]      reg_addr,
    output logic [15:0]     reg_wdata,
    // Answers from the timer
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid
);
    // Idle bus at time zero
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 16'h0000;
    end

    // One write; released lines show the inverse of the last value
    // Period rewrites through here keep a watchdog fed
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; data taken in the cycle the answer stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d,
                      output logic ok);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rvalid;
        d  = reg_rdata;
    endtask
endmodule

// ==== testbench/timer_chk.sv ====
// Port-level assertions for the interval and watchdog timer.
// Assumes bench periods of at least two, so pulses never abut.
`timescale 1ns/1ps

module timer_chk
#(
    parameter bit WATCHDOG        = 1'b0,
    parameter bit START_STOP_CTRL = 1'b1
)
(
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         srst,
    // Register port
    input wire logic                         reg_wr,
    input wire logic                         reg_rd,
    input wire logic [timer_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [timer_pkg::REG_W-1:0]  reg_wdata,
    input wire logic [timer_pkg::REG_W-1:0]  reg_rdata,
    input wire logic                         reg_rvalid,
    // Events
    input wire logic                         irq,
    input wire logic                         timeout_pulse,
    input wire logic                         reset_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////
    // A stop write in a build where stopping is allowed
    sequence s_stop;
        START_STOP_CTRL && !WATCHDOG && reg_wr &&
        reg_addr == timer_pkg::CONTROL_IDX &&
        reg_wdata[timer_pkg::STOP_BIT];
    endsequence
    // Counter quiet once the stop has landed
    sequence s_quiet;
        ##2 !timeout_pulse [*4];
    endsequence

    ////////////////////////////////////////////////////////////////////
    property p_pulse_once;
        timeout_pulse |=> !timeout_pulse;
    endproperty
    property p_no_reset_req;
        !WATCHDOG |-> !reset_request;
    endproperty
    property p_irq_rise;
        $rose(irq) |-> timeout_pulse || $past(reg_wr);
    endproperty
    property p_irq_fall;
        $fell(irq) |-> $past(reg_wr) || $past(srst);
    endproperty
    property p_irq_holds;
        irq && !reg_wr |=> irq;
    endproperty
    property p_rd_answer;
        reg_rd |=> reg_rvalid;
    endproperty
    property p_no_stray;
        !reg_rd |=> !reg_rvalid;
    endproperty
    property p_stop_quiet;
        s_stop |-> s_quiet;
    endproperty

    a_pulse_once: assert property (p_pulse_once)
        else $error("timeout pulse wider than one cycle");
    a_no_reset_req: assert property (p_no_reset_req)
        else $error("reset request without watchdog build");
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose without zero or enable write");
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell without a register write");
    a_irq_holds: assert property (p_irq_holds)
        else $error("irq dropped with no write");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered next cycle");
    a_no_stray: assert property (p_no_stray)
        else $error("read valid without a read");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("pulse after stop was written");
endmodule

bind interval_watchdog_timer timer_chk
#(
    .WATCHDOG        (WATCHDOG),
    .START_STOP_CTRL (START_STOP_CTRL)
)
chk_u
(
    .clk           (clk),
    .srst          (srst),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_rdata     (reg_rdata),
    .reg_rvalid    (reg_rvalid),
    .irq           (irq),
    .timeout_pulse (timeout_pulse),
    .reset_request (reset_request)
);
